// ===== dinfd_assertions.sv
// checker for the apb side and the pulse outputs of dinfd_top
// assumes it is bound to dinfd_top and sees only its ports
`timescale 1ns/1ps
module dinfd_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire fault_reset,
  input wire ext_fault,
  input wire freq_up,
  input wire freq_down,
  input wire freq_clear
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_pulse_gone(sig);
    !sig ##1 1'b1;
  endsequence
  property p_ready;
    s_access |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_unmapped;
    s_access ##0 (paddr > 12'h024 || paddr[1:0] != 2'b00) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    s_access ##0 (paddr <= 12'h024 && paddr[1:0] == 2'b00) |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_fault_pulse;
    fault_reset |=> s_pulse_gone(fault_reset);
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault reset too long");
  property p_ext_pulse;
    ext_fault |=> s_pulse_gone(ext_fault);
  endproperty
  a_ext_pulse: assert property (p_ext_pulse) else $error("external fault too long");
  property p_updown;
    !(freq_up && freq_down);
  endproperty
  a_updown: assert property (p_updown) else $error("up and down together");
  property p_clear;
    freq_clear |-> !freq_up && !freq_down ##1 !freq_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear pulse not clean");
endmodule
bind dinfd_top dinfd_checker dinfd_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .fault_reset(fault_reset), .ext_fault(ext_fault),
  .freq_up(freq_up), .freq_down(freq_down), .freq_clear(freq_clear));

// ===== dinfd_bench.sv
// self-checking bench for dinfd_top
// assumes the switch model drives the terminals, apb on pclk
`timescale 1ns/1ps
module dinfd_bench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [5:0] want = 6'h00;
  reg [31:0] rd;
  reg err;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [5:0] terminal_in;
  wire [3:0] speed_step;
  wire [1:0] ramp_time_set;
  wire [1:0] pulse_input_a;
  integer n_fail = 0;
  integer n_compared = 0;
  integer k;
  always #5 pclk = ~pclk;
  dinfd_switches dinfd_switches_i (.want(want), .terminal_in(terminal_in));
  dinfd_top dinfd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .terminal_in(terminal_in), .run_fwd(), .run_rev(), .three_wire_ctrl(), .jog_fwd(), .jog_rev(),
    .coast_stop(), .fault_reset(), .pause_run(), .ext_fault(), .freq_up(), .freq_down(), .freq_clear(),
    .sel_b_channel(), .sel_comb_a(), .sel_comb_b(), .speed_step(speed_step),
    .ramp_time_set(ramp_time_set), .pulse_input_a(pulse_input_a));
  task test_done;
    begin
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 20) begin
        t = t + 1;
        @(posedge pclk);
      end
      if (t == 20) begin
        n_fail = n_fail + 1;
        test_done;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next call never reassigns psel in this time step
      @(posedge pclk);
    end
  endtask
  // three edges through the synchroniser and output register, plus margin
  task put(input [5:0] v);
    begin
      want <= v;
      repeat (6) @(posedge pclk);
    end
  endtask
  task clr_cfg;
    for (k = 0; k < 7; k = k + 1)
      apb(1'b1, k[9:0] << 2, 32'h00000000);
  endtask
  function [31:0] exp_cmd(input [4:0] c);
    case (c)
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06: exp_cmd = 32'h00000001 << (6'd32 - c);
      5'h08: exp_cmd = 32'h02000000;
      5'h0A, 5'h0B: exp_cmd = 32'h00000001 << (6'd34 - c);
      5'h0D, 5'h0E, 5'h0F: exp_cmd = 32'h00000001 << (6'd35 - c);
      default: exp_cmd = 32'h00000000;
    endcase
  endfunction
  task t_regs;
    begin
      for (k = 0; k < 7; k = k + 1) begin
        apb(1'b0, k[9:0] << 2, 32'h00000000);
        chk(rd, 32'h00000000);
      end
      apb(1'b0, 12'h030, 32'h00000000);
      chk({31'h0, err}, 32'h00000001);
    end
  endtask
  task t_codes;
    integer c;
    begin
      for (c = 0; c < 24; c = c + 1) begin
        apb(1'b1, 12'h024, 32'h0000000F);
        apb(1'b1, 12'h008, c);
        put(6'h04);
        apb(1'b0, 12'h020, 32'h00000000);
        chk(rd, exp_cmd(c[4:0]));
        apb(1'b0, 12'h024, 32'h00000000);
        chk(rd, c == 6 ? 1 : c == 7 ? 2 : c == 9 ? 4 : c == 12 ? 8 : 0);
        put(6'h00);
      end
      apb(1'b1, 12'h000, 32'h00000001);
      apb(1'b1, 12'h004, 32'h00000008);
      put(6'h03);
      apb(1'b0, 12'h020, 32'h00000000);
      chk(rd, 32'h82000000);
      put(6'h01);
      apb(1'b0, 12'h020, 32'h00000000);
      chk(rd, 32'h80000000);
    end
  endtask
  task t_steps;
    integer v;
    begin
      clr_cfg;
      for (k = 0; k < 5; k = k + 1)
        apb(1'b1, k[9:0] << 2, 16 + k);
      for (v = 0; v < 16; v = v + 1) begin
        put(v[5:0]);
        chk({28'h0, speed_step}, v);
      end
      put(6'h05);
      put(6'h15);
      put(6'h1A);
      chk({28'h0, speed_step}, 32'h00000005);
      put(6'h0A);
      chk({28'h0, speed_step}, 32'h0000000A);
    end
  endtask
  task t_ramp;
    integer v;
    begin
      clr_cfg;
      apb(1'b1, 12'h000, 32'h00000015);
      apb(1'b1, 12'h004, 32'h00000016);
      for (v = 0; v < 4; v = v + 1) begin
        put(v[5:0]);
        chk({30'h0, ramp_time_set}, v);
      end
    end
  endtask
  task t_pulse;
    begin
      clr_cfg;
      apb(1'b1, 12'h018, 32'h00000003);
      apb(1'b1, 12'h010, 32'h00000001);
      put(6'h10);
      chk({30'h0, pulse_input_a}, 32'h00000001);
      apb(1'b0, 12'h020, 32'h00000000);
      chk(rd, 32'h00000000);
      apb(1'b1, 12'h018, 32'h00000000);
      put(6'h10);
      apb(1'b0, 12'h020, 32'h00000000);
      chk(rd, 32'h80000000);
      apb(1'b1, 12'h010, 32'h00000000);
      apb(1'b1, 12'h000, 32'h00000001);
      apb(1'b1, 12'h018, 32'h00000100);
      put(6'h00);
      apb(1'b0, 12'h020, 32'h00000000);
      chk(rd, 32'h80000000);
      apb(1'b0, 12'h01C, 32'h00000000);
      chk(rd, 32'h00000001);
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_codes;
    t_steps;
    t_ramp;
    t_pulse;
    test_done;
  end
endmodule

// ===== dinfd_consts.vh
// constants for the digital input function decoder
// assumes inclusion by dinfd_top.v only
`ifndef DINFD_CONSTS_VH
`define DINFD_CONSTS_VH
`define DINFD_FN_NONE 5'h00
`define DINFD_FN_FWD 5'h01
`define DINFD_FN_REV 5'h02
`define DINFD_FN_3WIRE 5'h03
`define DINFD_FN_JOGF 5'h04
`define DINFD_FN_JOGR 5'h05
`define DINFD_FN_COAST 5'h06
`define DINFD_FN_FRST 5'h07
`define DINFD_FN_PAUSE 5'h08
`define DINFD_FN_EXTF 5'h09
`define DINFD_FN_UP 5'h0A
`define DINFD_FN_DOWN 5'h0B
`define DINFD_FN_CLR 5'h0C
`define DINFD_FN_SWAB 5'h0D
`define DINFD_FN_SWCA 5'h0E
`define DINFD_FN_SWCB 5'h0F
`define DINFD_FN_STEP0 5'h10
`define DINFD_FN_STEP3 5'h13
`define DINFD_FN_STEPHOLD 5'h14
`define DINFD_FN_RAMP1 5'h15
`define DINFD_FN_RAMP2 5'h16
`define DINFD_OFF_FUNC0 12'h000
`define DINFD_OFF_FUNC1 12'h004
`define DINFD_OFF_FUNC2 12'h008
`define DINFD_OFF_FUNC3 12'h00C
`define DINFD_OFF_FUNC4 12'h010
`define DINFD_OFF_FUNC5 12'h014
`define DINFD_OFF_CTRL 12'h018
`define DINFD_OFF_LEVEL 12'h01C
`define DINFD_OFF_CMD 12'h020
`define DINFD_OFF_EVENT 12'h024
`endif

// ===== dinfd_switches.sv
// switch contacts on the six terminals
// assumes the bench names the wanted levels; contacts settle off the clock edge
`timescale 1ns/1ps
module dinfd_switches (
  input wire [5:0] want,
  output reg [5:0] terminal_in
);
  initial terminal_in = 6'h00;
  // asynchronous to pclk, so the decoder must synchronise
  always @(want) terminal_in = #3 want;
endmodule

// ===== dinfd_top.v
// digital input function decoder: six terminals mapped to drive commands
// assumes asynchronous terminal levels and an APB master on pclk
`timescale 1ns/1ps
`include "dinfd_consts.vh"

module dinfd_top #(
  parameter N_TERM = 6,
  parameter N_HS = 2
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  terminal_in,
  run_fwd,
  run_rev,
  three_wire_ctrl,
  jog_fwd,
  jog_rev,
  coast_stop,
  fault_reset,
  pause_run,
  ext_fault,
  freq_up,
  freq_down,
  freq_clear,
  sel_b_channel,
  sel_comb_a,
  sel_comb_b,
  speed_step,
  ramp_time_set,
  pulse_input_a
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire [N_TERM-1:0] terminal_in;
  output reg run_fwd;
  output reg run_rev;
  output reg three_wire_ctrl;
  output reg jog_fwd;
  output reg jog_rev;
  output reg coast_stop;
  output reg fault_reset;
  output reg pause_run;
  output reg ext_fault;
  output reg freq_up;
  output reg freq_down;
  output reg freq_clear;
  output reg sel_b_channel;
  output reg sel_comb_a;
  output reg sel_comb_b;
  output reg [3:0] speed_step;
  output reg [1:0] ramp_time_set;
  output reg [N_HS-1:0] pulse_input_a;

  wire [N_TERM-1:0] sync2_q;
  wire [N_TERM-1:0] withhold;
  reg [5*N_TERM-1:0] func_q;
  reg [N_HS-1:0] hs_pulse_mode_q;
  reg [N_TERM-1:0] invert_q;
  wire [7:0] event_q;
  wire [N_TERM-1:0] act;
  wire [N_TERM-1:0] rise;
  wire [31:0] ctrl_rd;
  wire [31:0] cmd_rd;
  reg [31:0] lvl_d;
  reg [3:0] step_raw;
  reg [1:0] ramp_raw;
  reg up_lv;
  reg dn_lv;
  reg clr_rise;
  reg rst_rise;
  reg ext_rise;
  reg hold_lv;
  reg ab_lv;
  reg ca_lv;
  reg cb_lv;
  reg [31:0] cmd_word;
  reg [4:0] fcode;
  integer i;
  integer j;

  wire wr_en = psel & penable & pwrite;
  wire [2:0] word_idx = paddr[4:2];
  wire mapped = (paddr <= `DINFD_OFF_EVENT) && (paddr[1:0] == 2'h0);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // pulse-mode terminals are withheld so the decoder never sees raw pulse trains
  assign withhold = {hs_pulse_mode_q, {(N_TERM-N_HS){1'b0}}};

  // one conditioner per terminal: two sync flops, polarity, edge
  genvar g;
  generate
    for (g = 0; g < N_TERM; g = g + 1) begin : g_term
      dinfd_term_cond dinfd_term_cond_i (
        .pclk(pclk),
        .presetn(presetn),
        .pin(terminal_in[g]),
        .invert(invert_q[g]),
        .withhold(withhold[g]),
        .sync_lvl(sync2_q[g]),
        .act(act[g]),
        .rise(rise[g])
      );
    end
  endgenerate

  // level functions follow the terminal, action functions fire on assertion
  always @* begin
    cmd_word = 32'h0000_0000;
    step_raw = 4'h0;
    ramp_raw = 2'h0;
    up_lv = 1'b0;
    dn_lv = 1'b0;
    clr_rise = 1'b0;
    rst_rise = 1'b0;
    ext_rise = 1'b0;
    hold_lv = 1'b0;
    ab_lv = 1'b0;
    ca_lv = 1'b0;
    cb_lv = 1'b0;
    fcode = 5'h00;
    for (i = 0; i < N_TERM; i = i + 1) begin
      fcode = func_q[5*i +: 5];
      // one code per terminal is assumed, so or-ing the terminals is safe
      case (fcode)
        `DINFD_FN_NONE: ;
        `DINFD_FN_FWD: cmd_word[0] = cmd_word[0] | act[i];
        `DINFD_FN_REV: cmd_word[1] = cmd_word[1] | act[i];
        `DINFD_FN_3WIRE: cmd_word[2] = cmd_word[2] | act[i];
        `DINFD_FN_JOGF: cmd_word[3] = cmd_word[3] | act[i];
        `DINFD_FN_JOGR: cmd_word[4] = cmd_word[4] | act[i];
        `DINFD_FN_COAST: cmd_word[5] = cmd_word[5] | act[i];
        `DINFD_FN_FRST: rst_rise = rst_rise | rise[i];
        `DINFD_FN_PAUSE: cmd_word[7] = cmd_word[7] | act[i];
        `DINFD_FN_EXTF: ext_rise = ext_rise | rise[i];
        `DINFD_FN_UP: up_lv = up_lv | act[i];
        `DINFD_FN_DOWN: dn_lv = dn_lv | act[i];
        `DINFD_FN_CLR: clr_rise = clr_rise | rise[i];
        `DINFD_FN_SWAB: ab_lv = ab_lv | act[i];
        `DINFD_FN_SWCA: ca_lv = ca_lv | act[i];
        `DINFD_FN_SWCB: cb_lv = cb_lv | act[i];
        `DINFD_FN_STEPHOLD: hold_lv = hold_lv | act[i];
        `DINFD_FN_RAMP1: ramp_raw[0] = ramp_raw[0] | act[i];
        `DINFD_FN_RAMP2: ramp_raw[1] = ramp_raw[1] | act[i];
        default: begin
          if (fcode >= `DINFD_FN_STEP0 && fcode <= `DINFD_FN_STEP3)
            step_raw[fcode[1:0]] = step_raw[fcode[1:0]] | act[i];
        end
      endcase
    end
  end

  // outputs are registered; the step is held while the freeze terminal is on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_fwd <= 1'b0;
      run_rev <= 1'b0;
      three_wire_ctrl <= 1'b0;
      jog_fwd <= 1'b0;
      jog_rev <= 1'b0;
      coast_stop <= 1'b0;
      pause_run <= 1'b0;
      freq_up <= 1'b0;
      freq_down <= 1'b0;
      sel_b_channel <= 1'b0;
      sel_comb_a <= 1'b0;
      sel_comb_b <= 1'b0;
      speed_step <= 4'h0;
      ramp_time_set <= 2'h0;
      pulse_input_a <= {N_HS{1'b0}};
    end else begin
      run_fwd <= cmd_word[0];
      run_rev <= cmd_word[1];
      three_wire_ctrl <= cmd_word[2];
      jog_fwd <= cmd_word[3];
      jog_rev <= cmd_word[4];
      coast_stop <= cmd_word[5];
      // drop of the pause level lets the run sequencer resume where it was
      pause_run <= cmd_word[7];
      // clear wins over up/down in the same cycle
      freq_up <= up_lv & ~dn_lv & ~clr_rise;
      freq_down <= dn_lv & ~up_lv & ~clr_rise;
      sel_b_channel <= ab_lv;
      sel_comb_a <= ca_lv;
      sel_comb_b <= cb_lv;
      if (!hold_lv)
        speed_step <= step_raw;
      ramp_time_set <= ramp_raw;
      for (j = 0; j < N_HS; j = j + 1)
        pulse_input_a[j] <= hs_pulse_mode_q[j] & sync2_q[N_TERM-N_HS+j];
    end
  end

  // action functions: one-cycle pulses on the assertion edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reset <= 1'b0;
      ext_fault <= 1'b0;
      freq_clear <= 1'b0;
    end else begin
      fault_reset <= rst_rise;
      ext_fault <= ext_rise;
      freq_clear <= clr_rise;
    end
  end

  // sticky event capture, one flag per event source
  wire ev_clr = wr_en && (paddr == `DINFD_OFF_EVENT);
  wire [3:0] ev_set = {clr_rise, ext_rise, rst_rise, cmd_word[5]};
  assign event_q[7:4] = 4'h0;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_event
      dinfd_sticky dinfd_sticky_i (
        .pclk(pclk),
        .presetn(presetn),
        .set(ev_set[g]),
        .clr(ev_clr & pwdata[g]),
        .flag(event_q[g])
      );
    end
  endgenerate

  // configuration registers
  // codes above the table, 0x17 and up, fall to default and do nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= {5*N_TERM{1'b0}};
      hs_pulse_mode_q <= {N_HS{1'b0}};
      invert_q <= {N_TERM{1'b0}};
    end else if (wr_en && mapped) begin
      if (paddr < `DINFD_OFF_CTRL && word_idx < N_TERM)
        func_q[5*word_idx +: 5] <= pwdata[4:0];
      if (paddr == `DINFD_OFF_CTRL) begin
        hs_pulse_mode_q <= pwdata[N_HS-1:0];
        invert_q <= pwdata[8 +: N_TERM];
      end
    end
  end

  always @* begin
    lvl_d = 32'h0000_0000;
    lvl_d[N_TERM-1:0] = act;
    lvl_d[16 +: 4] = speed_step;
    lvl_d[20 +: 2] = ramp_time_set;
  end

  // readback words; unused bits read as zero
  assign ctrl_rd = {{(24-N_TERM){1'b0}}, invert_q, {(8-N_HS){1'b0}}, hs_pulse_mode_q};
  assign cmd_rd = {run_fwd, run_rev, three_wire_ctrl, jog_fwd, jog_rev, coast_stop,
                   pause_run, freq_up, freq_down, sel_b_channel, sel_comb_a,
                   sel_comb_b, 20'h00000};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `DINFD_OFF_FUNC0, `DINFD_OFF_FUNC1, `DINFD_OFF_FUNC2,
        `DINFD_OFF_FUNC3, `DINFD_OFF_FUNC4, `DINFD_OFF_FUNC5:
          prdata <= (word_idx < N_TERM) ? {27'h0, func_q[5*word_idx +: 5]} : 32'h0000_0000;
        `DINFD_OFF_CTRL: prdata <= ctrl_rd;
        `DINFD_OFF_LEVEL: prdata <= lvl_d;
        `DINFD_OFF_CMD: prdata <= cmd_rd;
        `DINFD_OFF_EVENT: prdata <= {24'h000000, event_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// per-terminal conditioning: synchroniser, polarity, pulse-mode gate, edge
// assumes pin is asynchronous to pclk
module dinfd_term_cond (
  pclk,
  presetn,
  pin,
  invert,
  withhold,
  sync_lvl,
  act,
  rise
);
  input wire pclk;
  input wire presetn;
  input wire pin;
  input wire invert;
  input wire withhold;
  output wire sync_lvl;
  output wire act;
  output wire rise;
  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  // only sync2_q reads sync1_q, so metastability stays in the first flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q <= act;
    end
  end

  assign sync_lvl = sync2_q;
  assign act = (sync2_q ^ invert) & ~withhold;
  // edge taken on the gated level, so re-enabling a high terminal counts
  assign rise = act & ~prev_q;
endmodule

// sticky flag, set by hardware and cleared by software
module dinfd_sticky (
  pclk,
  presetn,
  set,
  clr,
  flag
);
  input wire pclk;
  input wire presetn;
  input wire set;
  input wire clr;
  output wire flag;
  reg flag_q;
  // set wins: an event in the clearing cycle is never lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= set | (flag_q & ~clr);
    end
  end
  assign flag = flag_q;
endmodule
